// >>> core/pisp_device.sv
// What this block does
// (R01) Host keeps SCL at or below 400 kHz
// (R02) Byte after write address selects register
// (R03) Power-up loads all registers from defaults
// (R04) Undervoltage or hard reset restores defaults
// (R05) Acknowledge only 0x90 and 0x91
// (R06) No auto-increment; one register per read
// (R07) Device never drives START or STOP; entering or leaving sleep moves the data line even while SCL is high
// (R08) Sleep holds data line low
// (R09) Release data line before supplies enable
// (R10) Acknowledge each byte once addressed
// (R11) Release data line after any acknowledge bit
// (R12) Read: address, command, repeated START, data
// (R13) Write: address, command, one data byte
// (R14) Valid command loads pointer, invalid is refused
// (R15) Thermal or low-voltage fault enters sleep
// (R16) Normal mode only after power-good checks
// (R17) Write commits only at acknowledge end
// (R18) STOP waits for START; repeated START equals START
// (R19) Read-only write: ack command, refuse data
// (R20) Pointer persists across transactions
`timescale 1ns/1ps
module pisp_device (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Power management
  input wire logic supply_undervoltage_lockout,
  input wire logic hard_reset_pin,
  input wire logic thermal_fault,
  input wire logic low_voltage_fault,
  input wire logic power_good,
  // Serial bus
  pisp_bus_if.device bus,
  // Register file user side, sleep and supply status
  input wire logic [7:0] reg_rd_addr,
  output logic [7:0] reg_rd_data,
  output logic [7:0] reg_ptr,
  output logic reg_wr_pulse,
  output logic [7:0] reg_wr_addr,
  output logic [7:0] reg_wr_data,
  output logic sleep_mode,
  output logic supplies_enable
);
  import pisp_pkg::*;

  typedef enum logic [2:0] {
    PISP_WAIT, PISP_RX, PISP_ACK, PISP_TX, PISP_TX_ACK
  } pisp_state_t;
  typedef enum logic [1:0] {
    PISP_B_ADDR, PISP_B_CMD, PISP_B_DATA, PISP_B_DONE
  } pisp_byte_t;

  logic sda, scl_rise, scl_fall, start_seen, stop_seen;
  logic reg_reset;
  logic [7:0] regs [PISP_REG_COUNT];
  pisp_state_t state, next_state;
  pisp_byte_t phase, next_phase;
  logic [7:0] shift, next_shift;
  logic [2:0] bitcnt, next_bitcnt;
  logic byte_full, next_byte_full;
  logic ack_drive, next_ack_drive;
  logic tx_drive, next_tx_drive;
  logic [7:0] ptr, next_ptr;
  logic wr_go, next_wr_go;
  logic [7:0] wr_addr, next_wr_addr;
  logic [7:0] wr_data, next_wr_data;
  logic sleep, next_sleep;
  logic sup_en, next_sup_en;
  logic sda_oe, next_sda_oe;

  pisp_sync u_sync (.sys_clk(sys_clk), .rst(rst), .scl_pin(bus.scl),
    .sda_pin(bus.serial_data_pin), .scl(), .sda(sda), .scl_rise(scl_rise),
    .scl_fall(scl_fall), .start_seen(start_seen), .stop_seen(stop_seen));

  assign reg_reset = supply_undervoltage_lockout || !hard_reset_pin; // [R04]

  always_comb
  begin
    next_state = state;
    next_phase = phase;
    next_shift = shift;
    next_bitcnt = bitcnt;
    next_byte_full = byte_full;
    next_ack_drive = ack_drive;
    next_tx_drive = tx_drive;
    next_ptr = ptr; // [R20]
    next_wr_go = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    if (start_seen)
    begin
      next_state = PISP_RX; // [R18]
      next_phase = PISP_B_ADDR;
      next_bitcnt = 3'h0;
      next_byte_full = 1'b0;
      next_ack_drive = 1'b0;
      next_tx_drive = 1'b0;
    end
    else if (stop_seen || sleep)
    begin
      next_state = PISP_WAIT; // [R18] [R17]
      next_ack_drive = 1'b0;
      next_tx_drive = 1'b0;
    end
    else
    begin
      unique case (state)
        PISP_WAIT:
        begin
          next_ack_drive = 1'b0;
        end
        PISP_RX:
        begin
          if (scl_rise)
          begin
            next_shift = {shift[6:0], sda};
            next_bitcnt = bitcnt + 3'h1;
            next_byte_full = (bitcnt == 3'h7);
          end
          // Only the fall after the eighth bit opens the acknowledge slot
          if (scl_fall && byte_full)
          begin
            next_state = PISP_ACK;
            next_byte_full = 1'b0;
            unique case (phase)
              PISP_B_ADDR:
              begin
                next_ack_drive = (shift == PISP_WRITE_SLAVE_ADDRESS)
                  || (shift == PISP_READ_SLAVE_ADDRESS); // [R05] [R10]
                // Read address keeps this phase so its acknowledge step goes on to PISP_TX
                next_phase = (shift == PISP_READ_SLAVE_ADDRESS) ? PISP_B_ADDR : PISP_B_CMD;
              end
              PISP_B_CMD:
              begin
                next_ack_drive = pisp_reg_allowed(shift); // [R02] [R14]
                if (pisp_reg_allowed(shift))
                  next_ptr = shift;
                next_phase = PISP_B_DATA;
              end
              PISP_B_DATA:
              begin
                next_ack_drive = pisp_reg_writable(ptr); // [R19] [R13]
                next_wr_addr = ptr;
                next_wr_data = shift;
                next_phase = PISP_B_DONE;
              end
              PISP_B_DONE:
              begin
                next_ack_drive = 1'b0;
              end
            endcase
          end
        end
        PISP_ACK:
        begin
          if (scl_fall)
          begin
            next_ack_drive = 1'b0; // [R11]
            if (phase == PISP_B_ADDR && ack_drive)
            begin
              next_state = PISP_TX; // [R12]
              next_shift = regs[ptr[5:0]];
              next_tx_drive = !regs[ptr[5:0]][7];
              next_bitcnt = 3'h1;
            end
            else if (phase == PISP_B_DONE && ack_drive)
            begin
              next_wr_go = 1'b1; // [R17]
              next_state = PISP_WAIT; // [R13]
            end
            else if (ack_drive)
            begin
              next_state = PISP_RX;
              next_bitcnt = 3'h0;
            end
            else
              next_state = PISP_WAIT;
          end
        end
        PISP_TX:
        begin
          if (scl_fall)
          begin
            next_tx_drive = !shift[3'h7 - bitcnt];
            next_bitcnt = bitcnt + 3'h1;
            if (bitcnt == 3'h0)
            begin
              next_tx_drive = 1'b0; // [R11]
              next_state = PISP_TX_ACK;
            end
          end
        end
        PISP_TX_ACK:
        begin
          if (scl_fall)
            next_state = PISP_WAIT; // [R06]
        end
      endcase
    end
  end

  // Register file with default load
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      for (int i = 0; i < PISP_REG_COUNT; i++)
        regs[i] <= PISP_REG_DEFAULT; // [R03]
    else if (reg_reset)
      for (int i = 0; i < PISP_REG_COUNT; i++)
        regs[i] <= PISP_REG_DEFAULT; // [R04]
    else if (wr_go)
      regs[wr_addr[5:0]] <= wr_data;
  end

  always_comb
  begin
    next_sleep = thermal_fault || low_voltage_fault || !power_good; // [R15] [R16]
    next_sda_oe = next_sleep || ack_drive || tx_drive; // [R08] [R07]
    next_sup_en = !sleep && !next_sleep;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= PISP_WAIT;
      phase <= PISP_B_ADDR;
      shift <= 8'h00;
      bitcnt <= 3'h0;
      byte_full <= 1'b0;
      ack_drive <= 1'b0;
      tx_drive <= 1'b0;
      ptr <= PISP_PTR_RESET;
      wr_go <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      sleep <= 1'b1;
      sup_en <= 1'b0;
      sda_oe <= 1'b1;
      reg_rd_data <= 8'h00;
    end
    else
    begin
      state <= next_state;
      phase <= next_phase;
      shift <= next_shift;
      bitcnt <= next_bitcnt;
      byte_full <= next_byte_full;
      ack_drive <= next_ack_drive;
      tx_drive <= next_tx_drive;
      ptr <= reg_reset ? PISP_PTR_RESET : next_ptr;
      wr_go <= next_wr_go && !reg_reset;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      sleep <= next_sleep;
      sup_en <= next_sup_en; // [R09]
      sda_oe <= next_sda_oe;
      reg_rd_data <= regs[reg_rd_addr[5:0]];
    end
  end

  assign bus.sda_dev_out = 1'b0;
  assign bus.sda_dev_oe = sda_oe;
  assign reg_ptr = ptr;
  assign reg_wr_pulse = wr_go;
  assign reg_wr_addr = wr_addr;
  assign reg_wr_data = wr_data;
  assign sleep_mode = sleep;
  assign supplies_enable = sup_en;
endmodule : pisp_device

// >>> core/pisp_pkg.sv
package pisp_pkg;
  // Slave address bytes, direction bit included
  localparam logic [7:0] PISP_WRITE_SLAVE_ADDRESS = 8'h90;
  localparam logic [7:0] PISP_READ_SLAVE_ADDRESS = 8'h91;
  // Register space layout
  localparam int PISP_REG_COUNT = 48;
  localparam logic [7:0] PISP_LAST_REG = 8'h2e;
  localparam logic [7:0] PISP_RESERVED_LO = 8'h01;
  localparam logic [7:0] PISP_GAP_LO = 8'h28;
  localparam logic [7:0] PISP_GAP_HI = 8'h2d;
  localparam logic [7:0] PISP_RO_STATUS = 8'h02;
  localparam logic [7:0] PISP_RO_ADC_HI = 8'h1f;
  localparam logic [7:0] PISP_RO_ADC_LO = 8'h20;
  localparam logic [7:0] PISP_PTR_RESET = 8'h00;
  // Timing at 40 MHz
  localparam int PISP_CLK_HZ = 40000000;
  localparam int PISP_SCL_MAX_HZ = 400000;
  localparam int PISP_QUARTER_CYCLES = PISP_CLK_HZ / (PISP_SCL_MAX_HZ * 4);
  localparam logic [7:0] PISP_REG_DEFAULT = 8'h00;

  typedef enum logic [1:0] {
    PISP_CMD_WRITE,
    PISP_CMD_READ,
    PISP_CMD_READ_NOPTR
  } pisp_cmd_t;

  // Register may be pointed at
  function automatic logic pisp_reg_allowed(input logic [7:0] a);
    pisp_reg_allowed = (a > PISP_RESERVED_LO) && (a < PISP_LAST_REG)
      && !((a >= PISP_GAP_LO) && (a <= PISP_GAP_HI));
  endfunction : pisp_reg_allowed

  // Register may be written
  function automatic logic pisp_reg_writable(input logic [7:0] a);
    pisp_reg_writable = pisp_reg_allowed(a) && (a != PISP_RO_STATUS)
      && (a != PISP_RO_ADC_HI) && (a != PISP_RO_ADC_LO);
  endfunction : pisp_reg_writable
endpackage : pisp_pkg

// >>> core/pisp_bus_if.sv
`timescale 1ns/1ps
interface pisp_bus_if;
  logic scl_out;
  logic scl_oe;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic scl;
  logic serial_data_pin;

  // Open-drain wired AND with pull-up
  assign scl = !(scl_oe && !scl_out);
  assign serial_data_pin = !(sda_host_oe && !sda_host_out) && !(sda_dev_oe && !sda_dev_out);

  modport device (
    input scl,
    input serial_data_pin,
    output sda_dev_out,
    output sda_dev_oe
  );
  modport host (
    input scl,
    input serial_data_pin,
    output scl_out,
    output scl_oe,
    output sda_host_out,
    output sda_host_oe
  );
endinterface : pisp_bus_if

// >>> core/pisp_sync.sv
`timescale 1ns/1ps
module pisp_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Pin levels
  input wire logic scl_pin,
  input wire logic sda_pin,
  // Synchronised levels and events
  output logic scl,
  output logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic [1:0] next_scl_meta;
  logic [1:0] next_sda_meta;
  logic next_scl;
  logic next_sda;

  always_comb
  begin
    next_scl_meta = {scl_meta[0], scl_pin};
    next_sda_meta = {sda_meta[0], sda_pin};
    next_scl = scl_meta[1];
    next_sda = sda_meta[1];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl <= 1'b1;
      sda <= 1'b1;
    end
    else
    begin
      scl_meta <= next_scl_meta;
      sda_meta <= next_sda_meta;
      scl <= next_scl;
      sda <= next_sda;
    end
  end

  assign scl_rise = !scl && scl_meta[1];
  assign scl_fall = scl && !scl_meta[1];
  assign start_seen = scl && scl_meta[1] && sda && !sda_meta[1];
  assign stop_seen = scl && scl_meta[1] && !sda && sda_meta[1];
endmodule : pisp_sync

// >>> core/pisp_host.sv
`timescale 1ns/1ps
module pisp_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Command port
  input wire logic cmd_valid,
  input wire pisp_pkg::pisp_cmd_t cmd_kind,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic done,
  output logic [7:0] rd_data,
  output logic nack_seen,
  // Serial bus
  pisp_bus_if.host bus
);
  import pisp_pkg::*;

  typedef enum logic [2:0] {
    PISP_H_IDLE, PISP_H_START, PISP_H_BIT, PISP_H_STOP, PISP_H_END
  } pisp_hstate_t;

  pisp_hstate_t state, next_state;
  logic [7:0] tick, next_tick;
  logic [1:0] quarter, next_quarter;
  logic [3:0] bitn, next_bitn;
  logic [1:0] bytei, next_bytei;
  logic [7:0] tx, next_tx;
  logic [7:0] rx, next_rx;
  logic scl_o, next_scl_o;
  logic sda_o, next_sda_o;
  logic nack, next_nack;
  logic rdy, next_rdy;
  logic dn, next_dn;
  pisp_cmd_t kind, next_kind;
  logic [7:0] r_reg, next_r_reg;
  logic [7:0] r_data, next_r_data;
  logic [1:0] sm1;
  logic sda_in;
  logic en;

  // Host paces SCL at 400 kHz in quarter steps [R01]
  assign en = (tick == 8'(PISP_QUARTER_CYCLES - 1));

  function automatic logic [7:0] pick(input logic [1:0] b, input pisp_cmd_t k,
                                      input logic [7:0] r, input logic [7:0] d);
    if (b == 2'h0)
      pick = (k == PISP_CMD_READ_NOPTR) ? PISP_READ_SLAVE_ADDRESS : PISP_WRITE_SLAVE_ADDRESS;
    else if (b == 2'h1)
      pick = r;
    else if (b == 2'h2)
      pick = (k == PISP_CMD_WRITE) ? d : PISP_READ_SLAVE_ADDRESS;
    else
      pick = 8'hff;
  endfunction : pick

  always_comb
  begin
    next_tick = en ? 8'h00 : tick + 8'h01;
    next_state = state;
    next_quarter = quarter;
    next_bitn = bitn;
    next_bytei = bytei;
    next_tx = tx;
    next_rx = rx;
    next_scl_o = scl_o;
    next_sda_o = sda_o;
    next_nack = nack;
    next_rdy = 1'b0;
    next_dn = 1'b0;
    next_kind = kind;
    next_r_reg = r_reg;
    next_r_data = r_data;
    unique case (state)
      PISP_H_IDLE:
      begin
        next_rdy = 1'b1;
        if (cmd_valid && rdy)
        begin
          next_rdy = 1'b0;
          next_kind = cmd_kind;
          next_r_reg = cmd_reg;
          next_r_data = cmd_data;
          next_bytei = 2'h0;
          next_nack = 1'b0;
          next_tx = pick(2'h0, cmd_kind, cmd_reg, cmd_data);
          next_state = PISP_H_START;
          next_quarter = 2'h0;
        end
      end
      PISP_H_START:
      begin
        if (en)
        begin
          next_quarter = quarter + 2'h1;
          if (quarter == 2'h0)
          begin
            next_sda_o = 1'b1;
            next_scl_o = 1'b1;
          end
          else if (quarter == 2'h1)
            next_sda_o = 1'b0;
          else if (quarter == 2'h2)
          begin
            next_scl_o = 1'b0;
            next_bitn = 4'h0;
            next_quarter = 2'h0;
            next_state = PISP_H_BIT;
          end
        end
      end
      PISP_H_BIT:
      begin
        if (en)
        begin
          next_quarter = quarter + 2'h1;
          if (quarter == 2'h0)
          begin
            // Bit 8 is the acknowledge slot; host always releases it
            if (bitn < 4'h8)
              next_sda_o = (bytei == 2'h3) ? 1'b1 : tx[3'(4'h7 - bitn)];
            else
              next_sda_o = 1'b1; // Read data refused: not-acknowledge
          end
          else if (quarter == 2'h1)
            next_scl_o = 1'b1;
          else if (quarter == 2'h2)
          begin
            if (bitn < 4'h8)
              next_rx = {rx[6:0], sda_in};
            else if (bytei != 2'h3 && sda_in)
              next_nack = 1'b1;
          end
          else
          begin
            next_scl_o = 1'b0;
            next_bitn = bitn + 4'h1;
            if (bitn == 4'h8)
            begin
              next_bitn = 4'h0;
              next_bytei = bytei + 2'h1;
              next_tx = pick(bytei + 2'h1, kind, r_reg, r_data);
              if (nack || bytei == 2'h3 || (kind == PISP_CMD_READ_NOPTR && bytei == 2'h0))
                next_bytei = 2'h3;
              if (nack || bytei == 2'h3 || (kind == PISP_CMD_WRITE && bytei == 2'h2))
                next_state = PISP_H_STOP;
              else if (kind == PISP_CMD_READ && bytei == 2'h1)
              begin
                next_state = PISP_H_START; // Repeated START [R12]
                next_bytei = 2'h2;
              end
            end
          end
        end
      end
      PISP_H_STOP:
      begin
        if (en)
        begin
          next_quarter = quarter + 2'h1;
          if (quarter == 2'h0)
            next_sda_o = 1'b0;
          else if (quarter == 2'h1)
            next_scl_o = 1'b1;
          else if (quarter == 2'h2)
          begin
            next_sda_o = 1'b1;
            next_state = PISP_H_END;
          end
        end
      end
      PISP_H_END:
      begin
        next_dn = 1'b1;
        next_state = PISP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sm1 <= 2'h3;
      state <= PISP_H_IDLE;
      tick <= 8'h00;
      quarter <= 2'h0;
      bitn <= 4'h0;
      bytei <= 2'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      scl_o <= 1'b1;
      sda_o <= 1'b1;
      nack <= 1'b0;
      rdy <= 1'b0;
      dn <= 1'b0;
      kind <= PISP_CMD_WRITE;
      r_reg <= 8'h00;
      r_data <= 8'h00;
    end
    else
    begin
      sm1 <= {sm1[0], bus.serial_data_pin};
      state <= next_state;
      tick <= next_tick;
      quarter <= next_quarter;
      bitn <= next_bitn;
      bytei <= next_bytei;
      tx <= next_tx;
      rx <= next_rx;
      scl_o <= next_scl_o;
      sda_o <= next_sda_o;
      nack <= next_nack;
      rdy <= next_rdy;
      dn <= next_dn;
      kind <= next_kind;
      r_reg <= next_r_reg;
      r_data <= next_r_data;
    end
  end

  assign sda_in = sm1[1];
  assign bus.scl_out = 1'b0;
  assign bus.scl_oe = !scl_o;
  assign bus.sda_host_out = 1'b0;
  assign bus.sda_host_oe = !sda_o;
  assign cmd_ready = rdy;
  assign done = dn;
  assign rd_data = rx;
  assign nack_seen = nack;
endmodule : pisp_host

// >>> verification/pisp_bus_sva.sv
`timescale 1ns/1ps
module pisp_bus_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus wires
  input wire logic scl,
  input wire logic serial_data_pin,
  input wire logic sda_dev_oe,
  // Device status
  input wire logic thermal_fault,
  input wire logic low_voltage_fault,
  input wire logic power_good,
  input wire logic sleep_mode,
  input wire logic supplies_enable,
  input wire logic reg_wr_pulse
);
  logic [9:0] hold_cnt;
  logic [9:0] next_hold_cnt;

  // Length of one device drive outside sleep
  always_comb
  begin
    next_hold_cnt = 10'h0;
    if (sda_dev_oe && !sleep_mode)
    begin
      next_hold_cnt = hold_cnt + 10'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst) hold_cnt <= 10'h0;
    else hold_cnt <= next_hold_cnt;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_no_start_stop;
    power_good && !thermal_fault && !low_voltage_fault && !sleep_mode && !$past(sleep_mode)
      && scl && $past(scl) |-> $stable(sda_dev_oe);
  endproperty
  a_no_start_stop: assert property (p_no_start_stop)
    else $error("device moved data line while clock high");
  property p_sleep_low;
    sleep_mode && $past(sleep_mode) |-> !serial_data_pin;
  endproperty
  a_sleep_low: assert property (p_sleep_low)
    else $error("data line not low in sleep");
  property p_release_first;
    $rose(supplies_enable) |-> serial_data_pin && !$past(sda_dev_oe);
  endproperty
  a_release_first: assert property (p_release_first)
    else $error("supplies enabled before data line release");
  property p_fault_sleep;
    thermal_fault || low_voltage_fault |=> sleep_mode;
  endproperty
  a_fault_sleep: assert property (p_fault_sleep)
    else $error("fault without sleep");
  property p_normal_clean;
    !sleep_mode |-> $past(power_good) && !$past(thermal_fault) && !$past(low_voltage_fault);
  endproperty
  a_normal_clean: assert property (p_normal_clean)
    else $error("normal mode without power good");
  property p_drive_bounded;
    hold_cnt < 10'h3e8;
  endproperty
  a_drive_bounded: assert property (p_drive_bounded)
    else $error("device held data line too long");
  property p_commit_clock_low;
    reg_wr_pulse |-> !scl && !sleep_mode;
  endproperty
  a_commit_clock_low: assert property (p_commit_clock_low)
    else $error("write committed outside acknowledge end");
  property p_stop_idle;
    scl && $past(scl) && $rose(serial_data_pin) |=> !sda_dev_oe [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("device drove line after stop");

  c_write: cover property (reg_wr_pulse);
  c_sleep: cover property ($rose(sleep_mode));
  c_wake: cover property ($rose(supplies_enable));
endmodule : pisp_bus_sva

// >>> verification/pmic_i2c_slave_register_port_tb_top.sv
`timescale 1ns/1ps
module pmic_i2c_slave_register_port_tb_top;
  import pisp_pkg::*;
  logic sys_clk, rst, cmd_valid, cmd_ready, done, nack_seen;
  logic supply_undervoltage_lockout, hard_reset_pin, thermal_fault, low_voltage_fault;
  logic power_good, reg_wr_pulse, sleep_mode, supplies_enable;
  pisp_cmd_t cmd_kind;
  logic [7:0] cmd_reg, cmd_data, rd_data, reg_rd_addr, reg_rd_data, reg_ptr;
  logic [7:0] reg_wr_addr, reg_wr_data, wr_addr, wr_data;
  logic [7:0] bad_cmd [4] = '{8'h01, 8'h28, 8'h2d, 8'h2e};
  logic [7:0] ro_cmd [3] = '{8'h02, 8'h1f, 8'h20};
  logic [7:0] addr_try [3] = '{8'h90, 8'h92, 8'h00};
  int n_fail = 0;
  int n_compared = 0;
  int n_wr = 0;

  pisp_bus_if bus ();
  pisp_bus_if bus2 ();
  pisp_host i_pisp_host (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_reg(cmd_reg), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .done(done), .rd_data(rd_data), .nack_seen(nack_seen), .bus(bus));
  pisp_device i_pisp_device (.sys_clk(sys_clk), .rst(rst),
    .supply_undervoltage_lockout(supply_undervoltage_lockout), .hard_reset_pin(hard_reset_pin),
    .thermal_fault(thermal_fault), .low_voltage_fault(low_voltage_fault),
    .power_good(power_good), .bus(bus), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data),
    .reg_ptr(reg_ptr), .reg_wr_pulse(reg_wr_pulse), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .sleep_mode(sleep_mode), .supplies_enable(supplies_enable));
  // Second device faced by a hand-driven bus
  pisp_device i_pisp_device_2 (.sys_clk(sys_clk), .rst(rst),
    .supply_undervoltage_lockout(supply_undervoltage_lockout), .hard_reset_pin(hard_reset_pin),
    .thermal_fault(thermal_fault), .low_voltage_fault(low_voltage_fault),
    .power_good(power_good), .bus(bus2), .reg_rd_addr(8'h00), .reg_rd_data(), .reg_ptr(),
    .reg_wr_pulse(), .reg_wr_addr(), .reg_wr_data(), .sleep_mode(), .supplies_enable());
  pisp_bus_sva i_pisp_bus_sva (.sys_clk(sys_clk), .rst(rst), .scl(bus.scl),
    .serial_data_pin(bus.serial_data_pin), .sda_dev_oe(bus.sda_dev_oe),
    .thermal_fault(thermal_fault), .low_voltage_fault(low_voltage_fault),
    .power_good(power_good), .sleep_mode(sleep_mode), .supplies_enable(supplies_enable),
    .reg_wr_pulse(reg_wr_pulse));

  always @(negedge sys_clk)
  begin
    if (reg_wr_pulse === 1'b1)
    begin
      n_wr++;
      wr_addr = reg_wr_addr;
      wr_data = reg_wr_data;
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk

  task automatic do_cmd(input pisp_cmd_t k, input logic [7:0] r, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (cmd_ready !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_reg <= r;
    cmd_data <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (done !== 1'b1 && n < 9000);
    chk("done", 8'h01, {7'h0, done});
  endtask : do_cmd

  task automatic t_write_read();
    int w;
    w = n_wr;
    do_cmd(PISP_CMD_WRITE, 8'h05, 8'ha5);
    chk("write nack", 8'h00, {7'h0, nack_seen});
    chk("write count", 8'h01, 8'(n_wr - w));
    chk("write addr", 8'h05, wr_addr);
    chk("write data", 8'ha5, wr_data);
    do_cmd(PISP_CMD_WRITE, 8'h27, 8'h3c);
    chk("top data", 8'h3c, wr_data);
    do_cmd(PISP_CMD_READ_NOPTR, 8'h00, 8'h00);
    chk("noptr data", 8'h3c, rd_data);
    do_cmd(PISP_CMD_READ, 8'h05, 8'h00);
    chk("read data", 8'ha5, rd_data);
    chk("read nack", 8'h00, {7'h0, nack_seen});
  endtask : t_write_read

  task automatic t_bad_cmd();
    int w;
    w = n_wr;
    foreach (bad_cmd[i])
    begin
      do_cmd(PISP_CMD_WRITE, bad_cmd[i], 8'h11);
      chk("bad cmd nack", 8'h01, {7'h0, nack_seen});
      chk("bad cmd ptr", 8'h05, reg_ptr);
    end
    chk("bad cmd writes", 8'h00, 8'(n_wr - w));
    do_cmd(PISP_CMD_READ_NOPTR, 8'h00, 8'h00);
    chk("kept ptr data", 8'ha5, rd_data);
  endtask : t_bad_cmd

  task automatic t_ro_write();
    int w;
    w = n_wr;
    foreach (ro_cmd[i])
    begin
      do_cmd(PISP_CMD_WRITE, ro_cmd[i], 8'h55);
      chk("ro nack", 8'h01, {7'h0, nack_seen});
      chk("ro ptr", ro_cmd[i], reg_ptr);
    end
    chk("ro writes", 8'h00, 8'(n_wr - w));
    do_cmd(PISP_CMD_READ_NOPTR, 8'h00, 8'h00);
    chk("ro read", 8'h00, rd_data);
  endtask : t_ro_write

  task automatic put(input logic s, input logic c);
    @(posedge sys_clk);
    bus2.sda_host_oe <= !s;
    bus2.scl_oe <= !c;
    repeat (24) @(posedge sys_clk);
  endtask : put

  task automatic t_foreign();
    foreach (addr_try[i])
    begin
      put(1'b1, 1'b1);
      put(1'b0, 1'b1);
      put(1'b0, 1'b0);
      for (int b = 7; b >= 0; b--)
      begin
        put(addr_try[i][b], 1'b0);
        put(addr_try[i][b], 1'b1);
        put(addr_try[i][b], 1'b0);
      end
      put(1'b1, 1'b0);
      put(1'b1, 1'b1);
      @(negedge sys_clk);
      chk("address ack", {7'h0, addr_try[i] != 8'h90}, {7'h0, bus2.serial_data_pin});
      put(1'b1, 1'b0);
      put(1'b0, 1'b0);
      put(1'b0, 1'b1);
      put(1'b1, 1'b1);
    end
  endtask : t_foreign

  task automatic t_sleep();
    int n;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge sys_clk);
      thermal_fault <= (i == 0);
      low_voltage_fault <= (i == 1);
      power_good <= (i != 2);
      repeat (4) @(negedge sys_clk);
      chk("sleep", 8'h01, {7'h0, sleep_mode});
      chk("sleep pin", 8'h00, {7'h0, bus.serial_data_pin});
      chk("sleep supplies", 8'h00, {7'h0, supplies_enable});
      @(posedge sys_clk);
      thermal_fault <= 1'b0;
      low_voltage_fault <= 1'b0;
      power_good <= 1'b1;
      n = 0;
      do
      begin
        @(negedge sys_clk);
        n++;
      end
      while (supplies_enable !== 1'b1 && n < 50);
      chk("wake pin", 8'h01, {7'h0, bus.serial_data_pin});
      chk("wake mode", 8'h00, {7'h0, sleep_mode});
      repeat (10) @(posedge sys_clk);
    end
  endtask : t_sleep

  task automatic t_reset();
    for (int src = 0; src < 2; src++)
    begin
      do_cmd(PISP_CMD_WRITE, 8'h05, 8'ha5);
      chk("kept data", 8'ha5, reg_rd_data);
      @(posedge sys_clk);
      hard_reset_pin <= (src != 0);
      supply_undervoltage_lockout <= (src == 1);
      @(posedge sys_clk);
      hard_reset_pin <= 1'b1;
      supply_undervoltage_lockout <= 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("reset data", 8'h00, reg_rd_data);
      chk("reset ptr", 8'h00, reg_ptr);
      repeat (20) @(posedge sys_clk);
    end
  endtask : t_reset

  task automatic stop_test();
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = PISP_CMD_WRITE;
    cmd_reg = 8'h00;
    cmd_data = 8'h00;
    supply_undervoltage_lockout = 1'b0;
    hard_reset_pin = 1'b1;
    thermal_fault = 1'b0;
    low_voltage_fault = 1'b0;
    power_good = 1'b1;
    reg_rd_addr = 8'h05;
    bus2.scl_out = 1'b0;
    bus2.scl_oe = 1'b0;
    bus2.sda_host_out = 1'b0;
    bus2.sda_host_oe = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("power-up data", 8'h00, reg_rd_data);
    t_write_read();
    t_bad_cmd();
    t_ro_write();
    t_foreign();
    t_sleep();
    t_reset();
    stop_test();
  end

  // Cut a hang short
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end
endmodule : pmic_i2c_slave_register_port_tb_top
